// ==== design/serial_port_regs.svh ====
// register offsets, field positions and reset values for the start-stop serial port
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

`define RX_BUF_OFS      12'h000
`define TX_BUF_OFS      12'h004
`define BAUD_OFS        12'h008
`define STATUS_OFS      12'h00C
`define COMMAND_OFS     12'h010
`define MODEM_CMD_OFS   12'h014

// status bits
`define ST_TX_EMPTY     0
`define ST_RX_FULL      1
`define ST_OVERRUN      2
`define ST_FRAMING      3
`define ST_PARITY       4
`define ST_TX_INT       5
`define ST_TX_END_INT   6
`define ST_RX_INT       7
`define ST_ERR_INT      8
`define ST_TX_BUSY      9

// command bits
`define CM_MODE         0
`define CM_TX_EN        1
`define CM_RX_EN        2
`define CM_LEN7         3
`define CM_FLAG_MODE    4
`define CM_PAR_LO       5
`define CM_PAR_HI       6
`define CM_FLAG_VAL     7
`define CM_STOP2        8
`define CM_TXE_IE       9
`define CM_TXEND_IE     10
`define CM_RX_IE        11
`define CM_ERR_IE       12
`define CM_MASTER_IE    13
`define CM_WIDTH        14

// modem command bit
`define MC_AUTO_EN      8

// baud register: prescale in [15:8], adjust in [7:0]
`define BAUD_RESET      16'h01FF
`define OVERSAMPLE      16
`define SAMPLE_MID      7

`endif

// ==== design/serial_port_pkg.sv ====
// types shared by the serial port design
// assumes the register header is included by users of the constants
package serial_port_pkg;
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP
  } rx_state_type;
endpackage

// ==== design/baud_tick_gen.sv ====
// baud tick generator: one pulse every prescale*(256-adjust) clocks
// assumes prescale and adjust are static register fields on the same clock
`timescale 1ns/10ps
`default_nettype none

module baud_tick_gen #(
  parameter int PRE_W = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [PRE_W-1:0] prescale,
  input  wire logic [7:0]       adjust,
  output logic                  tick
);
  logic [PRE_W-1:0] pre_cnt_ff;
  logic [8:0]       div_cnt_ff;
  logic [8:0]       div_top;
  logic             pre_wrap;

  if (PRE_W < 1 || PRE_W > 16) begin : g_bad_pre_w
    $error("baud_tick_gen: PRE_W out of range");
  end

  // prescale of zero is treated as one so the port never stalls
  assign pre_wrap = (pre_cnt_ff + {{(PRE_W-1){1'b0}}, 1'b1} >= prescale);
  assign div_top  = 9'h100 - {1'b0, adjust};

  always_ff @(posedge clk) begin
    if (srst) begin
      pre_cnt_ff <= '0;
      div_cnt_ff <= 9'h000;
      tick       <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_wrap) begin
        pre_cnt_ff <= '0;
        if (div_cnt_ff + 9'h001 >= div_top) begin
          div_cnt_ff <= 9'h000;
          tick       <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff + 9'h001;
        end
      end else begin
        pre_cnt_ff <= pre_cnt_ff + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

`default_nettype wire

// ==== design/serial_port.sv ====
// start-stop serial port with apb register access
// assumes rxd and cts come from pins; txd drives a pin directly
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_regs.svh"

// Behaviour
// - start-stop mode when mode bit is zero
// - bit rate is clk/(16*n*(256-P))
// - start on enable, or enable plus cts
// - start bit, then 8 or 7 bits
// - parity even/odd, flag bit, or nothing
// - one or two stop bits sent
// - empty flag rises, transmit interrupt flag sets
// - frame end with empty buffer ends transmission
// - receive only when auto-enable off, enabled
// - falling edge starts; high start bit abandons
// - shift 8 or 7 received data bits
// - receive parity or flag bit per settings
// - only one stop bit examined
// - buffer keeps value on flag mismatch/overrun
// - receive-full sets, receive interrupt flag sets
// - full flag still set gives overrun
// - zero stop bit is framing error
// - parity mismatch sets parity error
// - any error flag raises error interrupt
module serial_port (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        cts,
  output logic             txd,
  output logic             irq
);
  logic [7:0]  rx_holding_buffer_ff;
  logic [7:0]  tx_holding_buffer_ff;
  logic [15:0] baud_rate_reg_ff;
  logic [`CM_WIDTH-1:0] serial_command_reg_ff;
  logic        auto_enable_ff;
  logic        tx_buffer_empty_flag_ff;
  logic        rx_buffer_full_flag_ff;
  logic        overrun_flag_ff;
  logic        framing_flag_ff;
  logic        parity_error_flag_ff;
  logic        tx_end_int_flag_ff;
  logic [1:0]  rxd_sync_ff;
  logic [1:0]  cts_sync_ff;
  logic        rxd_prev_ff;

  serial_port_pkg::tx_state_type tx_state_ff;
  serial_port_pkg::rx_state_type rx_state_ff;
  logic [3:0]  tx_os_ff;
  logic [2:0]  tx_bit_ff;
  logic [7:0]  tx_shift_ff;
  logic        tx_par_ff;
  logic        tx_stop2_ff;
  logic [3:0]  rx_os_ff;
  logic [2:0]  rx_bit_ff;
  logic [7:0]  rx_shift_ff;
  logic        rx_par_ff;
  logic        rx_extra_ff;

  logic        tick;
  logic        wr_en;
  logic        rd_en;
  logic        len7;
  logic        flag_mode;
  logic [1:0]  parity_field;
  logic        has_extra;
  logic        start_ok;
  logic        rx_allowed;
  logic        rx_fall;
  logic        tx_done;
  logic        rx_done;
  logic        rx_stop_bad;
  logic        rx_par_bad;
  logic        rx_flag_bad;
  logic        tx_take;
  logic        tx_empty_int_flag;
  logic        rx_full_int_flag;
  logic        error_int_flag;
  logic        master_int_enable;
  logic [31:0] status_word;
  logic [31:0] nxt_prdata;

  function automatic logic parity_of(input logic [7:0] d, input logic seven, input logic odd);
    parity_of = ^(seven ? {1'b0, d[6:0]} : d) ^ odd;
  endfunction

  baud_tick_gen #(
    .PRE_W (8)
  ) u_baud (
    .clk      (clk),
    .srst     (srst),
    .prescale (baud_rate_reg_ff[15:8]),
    .adjust   (baud_rate_reg_ff[7:0]),
    .tick     (tick)
  );

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  assign len7              = serial_command_reg_ff[`CM_LEN7];
  assign flag_mode         = serial_command_reg_ff[`CM_FLAG_MODE];
  assign parity_field      = serial_command_reg_ff[`CM_PAR_HI:`CM_PAR_LO];
  assign master_int_enable = serial_command_reg_ff[`CM_MASTER_IE];
  // flag mode with nonzero parity field adds no extra bit
  assign has_extra = flag_mode ? (parity_field == 2'b00) : parity_field[1];

  // the core ignores the synchronous-clock mode; mode bit one keeps it quiet
  assign start_ok = !serial_command_reg_ff[`CM_MODE] && serial_command_reg_ff[`CM_TX_EN] &&
                    (!auto_enable_ff || cts_sync_ff[1]);
  assign rx_allowed = !serial_command_reg_ff[`CM_MODE] && !auto_enable_ff &&
                      serial_command_reg_ff[`CM_RX_EN];
  assign rx_fall = rxd_prev_ff && !rxd_sync_ff[1];

  assign tx_take = (tx_state_ff == serial_port_pkg::TX_IDLE) && !tx_buffer_empty_flag_ff &&
                   start_ok;
  assign tx_done = (tx_state_ff == serial_port_pkg::TX_STOP) && tick && tx_os_ff == 4'hF &&
                   !tx_stop2_ff;

  // stop bit is judged a full bit after the last data or extra-bit sample, at its centre
  assign rx_done     = (rx_state_ff == serial_port_pkg::RX_STOP) && tick &&
                       rx_os_ff == 4'hF;
  assign rx_stop_bad = !rxd_sync_ff[1];
  assign rx_par_bad  = !flag_mode && parity_field[1] &&
                       (parity_of(rx_shift_ff, len7, parity_field[0]) != rx_par_ff);
  assign rx_flag_bad = flag_mode && parity_field == 2'b00 &&
                       rx_extra_ff != serial_command_reg_ff[`CM_FLAG_VAL];

  assign tx_empty_int_flag = tx_buffer_empty_flag_ff && serial_command_reg_ff[`CM_TXE_IE] &&
                             master_int_enable;
  assign rx_full_int_flag  = rx_buffer_full_flag_ff && serial_command_reg_ff[`CM_RX_IE] &&
                             master_int_enable;
  assign error_int_flag    = (overrun_flag_ff || framing_flag_ff || parity_error_flag_ff) &&
                             serial_command_reg_ff[`CM_ERR_IE] && master_int_enable;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_TX_EMPTY]   = tx_buffer_empty_flag_ff;
    status_word[`ST_RX_FULL]    = rx_buffer_full_flag_ff;
    status_word[`ST_OVERRUN]    = overrun_flag_ff;
    status_word[`ST_FRAMING]    = framing_flag_ff;
    status_word[`ST_PARITY]     = parity_error_flag_ff;
    status_word[`ST_TX_INT]     = tx_empty_int_flag;
    status_word[`ST_TX_END_INT] = tx_end_int_flag_ff;
    status_word[`ST_RX_INT]     = rx_full_int_flag;
    status_word[`ST_ERR_INT]    = error_int_flag;
    status_word[`ST_TX_BUSY]    = tx_state_ff != serial_port_pkg::TX_IDLE;
  end

  always_comb begin
    case (paddr)
      `RX_BUF_OFS:    nxt_prdata = {24'h000000, rx_holding_buffer_ff};
      `TX_BUF_OFS:    nxt_prdata = {24'h000000, tx_holding_buffer_ff};
      `BAUD_OFS:      nxt_prdata = {16'h0000, baud_rate_reg_ff};
      `STATUS_OFS:    nxt_prdata = status_word;
      `COMMAND_OFS:   nxt_prdata = {{(32-`CM_WIDTH){1'b0}}, serial_command_reg_ff};
      `MODEM_CMD_OFS: nxt_prdata = {23'h000000, auto_enable_ff, 8'h00};
      default:        nxt_prdata = 32'h0000_0000;
    endcase
  end

  // read data is captured in setup so the access phase always answers in one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr[11:0] > `MODEM_CMD_OFS;
      if (rd_en) begin
        prdata <= nxt_prdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_holding_buffer_ff  <= 8'h00;
      baud_rate_reg_ff      <= `BAUD_RESET;
      serial_command_reg_ff <= '0;
      auto_enable_ff        <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `TX_BUF_OFS:    tx_holding_buffer_ff  <= pwdata[7:0];
        `BAUD_OFS:      baud_rate_reg_ff      <= pwdata[15:0];
        `COMMAND_OFS:   serial_command_reg_ff <= pwdata[`CM_WIDTH-1:0];
        `MODEM_CMD_OFS: auto_enable_ff        <= pwdata[`MC_AUTO_EN];
        default:        ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_sync_ff <= 2'b11;
      cts_sync_ff <= 2'b00;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_sync_ff <= {rxd_sync_ff[0], rxd};
      cts_sync_ff <= {cts_sync_ff[0], cts};
      rxd_prev_ff <= rxd_sync_ff[1];
    end
  end

  // status flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_buffer_empty_flag_ff <= 1'b1;
      rx_buffer_full_flag_ff  <= 1'b0;
      overrun_flag_ff         <= 1'b0;
      framing_flag_ff         <= 1'b0;
      parity_error_flag_ff    <= 1'b0;
      tx_end_int_flag_ff      <= 1'b0;
    end else begin
      if (tx_take) begin
        tx_buffer_empty_flag_ff <= 1'b1;
      end else if (wr_en && paddr == `STATUS_OFS && !pwdata[`ST_TX_EMPTY]) begin
        tx_buffer_empty_flag_ff <= 1'b0;
      end
      if (rx_done && !rx_flag_bad && !rx_buffer_full_flag_ff) begin
        rx_buffer_full_flag_ff <= 1'b1;
      end else if (wr_en && paddr == `STATUS_OFS && !pwdata[`ST_RX_FULL]) begin
        rx_buffer_full_flag_ff <= 1'b0;
      end
      if (rx_done && rx_buffer_full_flag_ff) begin
        overrun_flag_ff <= 1'b1;
      end else if (wr_en && paddr == `STATUS_OFS && !pwdata[`ST_OVERRUN]) begin
        overrun_flag_ff <= 1'b0;
      end
      if (rx_done && rx_stop_bad) begin
        framing_flag_ff <= 1'b1;
      end else if (wr_en && paddr == `STATUS_OFS && !pwdata[`ST_FRAMING]) begin
        framing_flag_ff <= 1'b0;
      end
      if (rx_done && rx_par_bad) begin
        parity_error_flag_ff <= 1'b1;
      end else if (wr_en && paddr == `STATUS_OFS && !pwdata[`ST_PARITY]) begin
        parity_error_flag_ff <= 1'b0;
      end
      if (tx_done && tx_buffer_empty_flag_ff && serial_command_reg_ff[`CM_TXEND_IE] &&
          master_int_enable) begin
        tx_end_int_flag_ff <= 1'b1;
      end else if (!serial_command_reg_ff[`CM_TXEND_IE] || !master_int_enable ||
                   (wr_en && paddr == `STATUS_OFS && !pwdata[`ST_TX_END_INT])) begin
        tx_end_int_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_holding_buffer_ff <= 8'h00;
    end else if (rx_done && !rx_flag_bad && !rx_buffer_full_flag_ff) begin
      rx_holding_buffer_ff <= len7 ? {1'b0, rx_shift_ff[6:0]} : rx_shift_ff;
    end
  end

  // transmitter: each bit lasts sixteen ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_state_ff <= serial_port_pkg::TX_IDLE;
      tx_os_ff    <= 4'h0;
      tx_bit_ff   <= 3'h0;
      tx_shift_ff <= 8'h00;
      tx_par_ff   <= 1'b0;
      tx_stop2_ff <= 1'b0;
      txd         <= 1'b1;
    end else begin
      case (tx_state_ff)
        serial_port_pkg::TX_IDLE: begin
          txd <= 1'b1;
          if (tx_take) begin
            tx_shift_ff <= tx_holding_buffer_ff;
            tx_par_ff   <= flag_mode ? serial_command_reg_ff[`CM_FLAG_VAL] :
                           parity_of(tx_holding_buffer_ff, len7, parity_field[0]);
            tx_state_ff <= serial_port_pkg::TX_START;
            tx_os_ff    <= 4'h0;
            txd         <= 1'b0;
          end
        end
        serial_port_pkg::TX_START: begin
          if (tick) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == 4'hF) begin
              tx_state_ff <= serial_port_pkg::TX_DATA;
              tx_bit_ff   <= 3'h0;
              txd         <= tx_shift_ff[0];
            end
          end
        end
        serial_port_pkg::TX_DATA: begin
          if (tick) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == 4'hF) begin
              tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
              tx_bit_ff   <= tx_bit_ff + 3'h1;
              if (tx_bit_ff == (len7 ? 3'h6 : 3'h7)) begin
                tx_stop2_ff <= serial_command_reg_ff[`CM_STOP2];
                tx_state_ff <= has_extra ? serial_port_pkg::TX_EXTRA : serial_port_pkg::TX_STOP;
                txd         <= has_extra ? tx_par_ff : 1'b1;
              end else begin
                txd <= tx_shift_ff[1];
              end
            end
          end
        end
        serial_port_pkg::TX_EXTRA: begin
          if (tick) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == 4'hF) begin
              tx_state_ff <= serial_port_pkg::TX_STOP;
              txd         <= 1'b1;
            end
          end
        end
        serial_port_pkg::TX_STOP: begin
          if (tick) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == 4'hF) begin
              if (tx_stop2_ff) begin
                tx_stop2_ff <= 1'b0;
              end else begin
                tx_state_ff <= serial_port_pkg::TX_IDLE;
              end
            end
          end
        end
        default: tx_state_ff <= serial_port_pkg::TX_IDLE;
      endcase
    end
  end

  // receiver: start bit sampled at the eighth tick after the detected falling edge, later bits every sixteen ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state_ff <= serial_port_pkg::RX_IDLE;
      rx_os_ff    <= 4'h0;
      rx_bit_ff   <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_par_ff   <= 1'b0;
      rx_extra_ff <= 1'b0;
    end else if (!rx_allowed) begin
      rx_state_ff <= serial_port_pkg::RX_IDLE;
    end else begin
      case (rx_state_ff)
        serial_port_pkg::RX_IDLE: begin
          rx_os_ff <= 4'h0;
          if (rx_fall) begin
            rx_state_ff <= serial_port_pkg::RX_START;
          end
        end
        serial_port_pkg::RX_START: begin
          if (tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
            if (rx_os_ff == 4'(`SAMPLE_MID)) begin
              rx_os_ff  <= 4'h0;
              rx_bit_ff <= 3'h0;
              rx_state_ff <= rxd_sync_ff[1] ? serial_port_pkg::RX_IDLE :
                             serial_port_pkg::RX_DATA;
            end
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
            if (rx_os_ff == 4'hF) begin
              rx_shift_ff <= len7 ? {1'b0, rxd_sync_ff[1], rx_shift_ff[6:1]} :
                             {rxd_sync_ff[1], rx_shift_ff[7:1]};
              rx_bit_ff   <= rx_bit_ff + 3'h1;
              if (rx_bit_ff == (len7 ? 3'h6 : 3'h7)) begin
                rx_state_ff <= has_extra ? serial_port_pkg::RX_EXTRA : serial_port_pkg::RX_STOP;
              end
            end
          end
        end
        serial_port_pkg::RX_EXTRA: begin
          if (tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
            if (rx_os_ff == 4'hF) begin
              rx_par_ff   <= rxd_sync_ff[1];
              rx_extra_ff <= rxd_sync_ff[1];
              rx_state_ff <= serial_port_pkg::RX_STOP;
            end
          end
        end
        serial_port_pkg::RX_STOP: begin
          if (tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
            if (rx_os_ff == 4'hF) begin
              rx_state_ff <= serial_port_pkg::RX_IDLE;
            end
          end
        end
        default: rx_state_ff <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= tx_empty_int_flag || tx_end_int_flag_ff || rx_full_int_flag || error_int_flag;
    end
  end
endmodule

`default_nettype wire

// ==== tb/serial_port_asserts.sv ====
// checker for the serial port: apb answers, bit lengths on txd, reset idle, irq masking
// assumes the baud register keeps its reset value, so one bit lasts 16 clocks
`timescale 1ns/10ps
`default_nettype none
module serial_port_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        cts,
  input wire logic        txd,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic setup;
  assign setup = psel && !penable;
  property p_ready_next; setup |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_far_err; setup && !pwrite && paddr > 12'h014 |=> pslverr && prdata == 32'h0; endproperty
  property p_near_ok; setup && paddr <= 12'h014 |=> !pslverr; endproperty
  property p_start_len; $fell(txd) |-> !txd [*8] ##1 !txd [*8]; endproperty
  property p_high_len; $rose(txd) |-> txd [*8] ##1 txd [*8]; endproperty
  property p_reset_idle; $fell(srst) |-> txd && !irq && !pready; endproperty
  // a command write dropping the master enable must silence irq within three edges
  property p_irq_mask;
    psel && penable && pwrite && pready && paddr == 12'h010 && !pwdata[13] |-> ##3 !irq;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  a_far_err: assert property (p_far_err)
    else $error("unmapped read not refused");
  a_near_ok: assert property (p_near_ok)
    else $error("error on mapped address");
  a_start_len: assert property (p_start_len)
    else $error("low bit shorter than 16 clocks");
  a_high_len: assert property (p_high_len)
    else $error("high bit shorter than 16 clocks");
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq stays with master enable off");
  c_frame: cover property ($fell(txd));
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
endmodule
bind serial_port serial_port_asserts i_serial_port_asserts (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .cts(cts), .txd(txd), .irq(irq)
);
`default_nettype wire

// ==== tb/serial_peer.sv ====
// remote start-stop device: captures frames from txd, sends frames on rxd
// assumes 16 clocks a bit; the bench sets len before each transmit
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  output logic     rxd,
  output logic     cts
);
  logic [11:0] got;
  int          len = 10;
  int          nframes = 0;
  logic        clear_to_send = 1'b1;
  assign cts = clear_to_send;
  initial rxd = 1'b1;
  always begin
    @(negedge txd);
    got = '0;
    // sample at mid-bit so edge jitter cannot flip a bit
    repeat (8) @(posedge clk);
    for (int i = 0; i < len; i++) begin
      got[i] = txd;
      if (i < len - 1) repeat (16) @(posedge clk);
    end
    nframes++;
  end
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  task automatic glitch();
    @(posedge clk);
    rxd <= 1'b0;
    repeat (4) @(posedge clk);
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// bench for the serial port: apb tasks, transmit, auto-enable and receive tables
// assumes baud stays at reset (16 clocks a bit) and a 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_regs.svh"
module tb;
  typedef struct {
    logic        keep;
    logic        flip;
    logic        stopv;
    logic [15:0] cmd;
    logic [7:0]  d;
    logic [7:0]  st;
    logic [7:0]  bf;
    logic        irq;
  } rx_case_type;
  logic        clk = 1'b0;
  logic        srst, psel, penable, pwrite, pready, pslverr, rxd, cts, txd, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          mismatches = 0;
  int          num_checks = 0;
  int          nf0;
  logic [7:0]  tx_dat [4] = '{8'hA5, 8'h35, 8'hC3, 8'h5A};
  logic [15:0] tx_cmd [4] = '{16'h0000, 16'h0048, 16'h0160, 16'h0090};
  rx_case_type rx_tab [9] = '{
    '{1'b0, 1'b0, 1'b1, 16'h3804, 8'hA5, 8'h02, 8'hA5, 1'b1},
    '{1'b1, 1'b0, 1'b1, 16'h3804, 8'h3C, 8'h06, 8'hA5, 1'b1},
    '{1'b0, 1'b0, 1'b1, 16'h384C, 8'hB5, 8'h02, 8'h35, 1'b1},
    '{1'b0, 1'b1, 1'b1, 16'h3844, 8'h96, 8'h12, 8'h96, 1'b1},
    '{1'b0, 1'b0, 1'b1, 16'h3964, 8'h60, 8'h02, 8'h60, 1'b1},
    '{1'b0, 1'b0, 1'b0, 16'h3804, 8'h81, 8'h0A, 8'h81, 1'b1},
    '{1'b0, 1'b1, 1'b1, 16'h3894, 8'h42, 8'h00, 8'h81, 1'b0},
    '{1'b0, 1'b0, 1'b1, 16'h3894, 8'h42, 8'h02, 8'h42, 1'b1},
    '{1'b0, 1'b0, 1'b1, 16'h3800, 8'h11, 8'h00, 8'h42, 1'b0}};
  always #2.5 clk = ~clk;
  serial_port i_serial_port (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .cts(cts), .txd(txd), .irq(irq));
  serial_peer i_serial_peer (.clk(clk), .txd(txd), .rxd(rxd), .cts(cts));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(32'(k < 20), 32'h1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] frame_of(input logic [7:0] d, input logic [15:0] c,
                                           input logic stopv, output int len);
    int          n;
    logic [11:0] f;
    n = c[3] ? 7 : 8;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[1+i] = d[i];
    len = 1 + n;
    if (c[6]) begin
      f[len] = ^(d & (c[3] ? 8'h7F : 8'hFF)) ^ c[5];
      len++;
    end else if (c[4]) begin
      f[len] = c[7];
      len++;
    end
    f[len] = stopv;
    len += c[8] ? 2 : 1;
    return f & ~(12'hFFF << len);
  endfunction
  task automatic tx_one(input logic [7:0] d, input logic [15:0] c);
    int          n0, k, len;
    logic [11:0] f;
    f = frame_of(d, c, 1'b1, len);
    i_serial_peer.len = len;
    n0 = i_serial_peer.nframes;
    k = 0;
    apb(1'b1, `COMMAND_OFS, {16'h0, c | 16'h2602});
    apb(1'b1, `TX_BUF_OFS, {24'h0, d});
    apb(1'b1, `STATUS_OFS, 32'h0);
    while (i_serial_peer.nframes == n0 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k < 1000), 32'h1);
    chk({20'h0, i_serial_peer.got}, {20'h0, f});
    repeat (40) @(posedge clk);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk(rdat & 32'h61, 32'h61);
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic rx_one(input rx_case_type c);
    int          len;
    logic [11:0] f;
    f = frame_of(c.d, c.cmd, c.stopv, len);
    if (c.flip) f[len-2] = ~f[len-2];
    // bit 0 written as 1 so the transmit buffer stays marked empty
    if (!c.keep) apb(1'b1, `STATUS_OFS, 32'h1);
    apb(1'b1, `COMMAND_OFS, {16'h0, c.cmd});
    i_serial_peer.send(f, len);
    repeat (40) @(posedge clk);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk(rdat & 32'h1E, {24'h0, c.st});
    apb(1'b0, `RX_BUF_OFS, 32'h0);
    chk(rdat, {24'h0, c.bf});
    chk({31'h0, irq}, {31'h0, c.irq});
    apb(1'b1, `COMMAND_OFS, {16'h0, c.cmd & 16'h1FFF});
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  // about 3700 clocks of tests; the limit leaves ample margin
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk(rdat, 32'h1);
    apb(1'b0, `BAUD_OFS, 32'h0);
    chk(rdat, 32'h1FF);
    apb(1'b0, 12'h020, 32'h0);
    chk(rdat, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) tx_one(tx_dat[i], tx_cmd[i]);
    $display("test transmit done");
    i_serial_peer.clear_to_send <= 1'b0;
    apb(1'b1, `MODEM_CMD_OFS, 32'h100);
    nf0 = i_serial_peer.nframes;
    fork
      tx_one(8'h69, 16'h0000);
      begin
        repeat (300) @(posedge clk);
        chk({31'h0, txd}, 32'h1);
        // a frame sent without cts would already have been captured by now
        chk(32'(i_serial_peer.nframes - nf0), 32'h0);
        i_serial_peer.clear_to_send <= 1'b1;
      end
    join
    apb(1'b1, `MODEM_CMD_OFS, 32'h0);
    $display("test auto enable done");
    for (int i = 0; i < 9; i++) rx_one(rx_tab[i]);
    apb(1'b1, `STATUS_OFS, 32'h1);
    apb(1'b1, `COMMAND_OFS, 32'h3804);
    i_serial_peer.glitch();
    // long enough for a wrongly accepted start to finish a whole frame
    repeat (200) @(posedge clk);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk(rdat & 32'h1E, 32'h0);
    $display("test receive done");
    give_verdict();
  end
endmodule
`default_nettype wire
